// File: core/tape_status_pkg.sv
package tape_status_pkg;

  // Register map, byte addresses
  localparam logic [11:0] ADDR_SEL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_GRP_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CONDITION = 12'h008;
  localparam logic [11:0] ADDR_READ_CHAR = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

  // Selected-drive status bit positions
  localparam int SEL_MAIN_AVAIL = 0;
  localparam int SEL_FWD_READY = 1;
  localparam int SEL_BWD_READY = 2;
  localparam int SEL_REWOUND = 3;
  localparam int SEL_PROTECT = 4;

  // Group status bit positions
  localparam int GRP_NO_WRITER = 0;
  localparam int GRP_WR_CLUTCH = 1;
  localparam int GRP_RD_FWD = 2;
  localparam int GRP_RD_REV = 3;
  localparam int GRP_WR_FWD = 4;
  localparam int GRP_RD_ALERT = 5;
  localparam int GRP_WR_ALERT = 6;
  localparam int GRP_PLASTIC = 7;

  // Interrupt event bit positions
  localparam int EV_CHAR = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_COND_CHANGE = 2;
  localparam int EV_BAD_TAPE = 3;
  localparam int EV_INTERVENE = 4;

  localparam int SEL_W = 5;
  localparam int GRP_W = 8;
  localparam int EV_W = 5;
  localparam int CHAR_W = 7;
  localparam int BUS_W = 8;
  localparam int SYNC_W = SEL_W + GRP_W + BUS_W;

  localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;

  // Selected-drive condition, decoded from the two ready lines
  typedef enum logic [1:0] {
    COND_BUSY_OR_HELD = 2'b00,
    COND_FWD_SET = 2'b01,
    COND_BWD_SET = 2'b10,
    COND_FIRST_BLOCK = 2'b11
  } drive_cond_t;

  // Selected-drive lines
  typedef struct packed {
    logic master_reel_protect;
    logic rewound_locked;
    logic backward_ready;
    logic forward_ready;
    logic main_unit_available;
  } sel_status_t;

  // Group lines, driven by whichever drive has read or write fired
  typedef struct packed {
    logic plastic_tape_mounted;
    logic write_bad_tape_alert;
    logic read_bad_tape_alert;
    logic write_drive_fwd;
    logic read_drive_rev;
    logic read_drive_fwd;
    logic write_clutch_engaged;
    logic no_writer_active;
  } grp_status_t;

  // Read bus: sprocket on top of seven information bits
  typedef struct packed {
    logic sprocket;
    logic [CHAR_W-1:0] info;
  } read_bus_t;

endpackage : tape_status_pkg

// File: core/level_sync.sv
`timescale 1ns/1ps
// Three-stage sampler; a change is accepted once stages two and three agree
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the domain
  output logic [WIDTH-1:0] sync_out // Filtered, synchronous levels
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  // Per-bit agreement filter; stage one feeds stage two only
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
      end
    end
  endgenerate

  // Shift and hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule : level_sync

// File: core/tape_unit_status_decoder.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Status split: selected-drive lines versus lines of the active drive
// - Both ready lines high means first-block condition
// - Both ready lines low means drive busy or held
// - main_unit_available low means operator intervention needed
module tape_unit_status_decoder
  import tape_status_pkg::*;
(
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire sel_status_t sel_lines, // Lines of the selected drive
  input wire grp_status_t grp_lines, // Lines of the active drive
  input wire read_bus_t read_bus_lines, // Read bus from reading drive
  output logic irq, // Level interrupt
  output logic first_block, // Selected drive in first-block state
  output logic drive_unavailable, // Selected drive busy or held
  output logic needs_operator // Operator intervention required
);

  // All three line groups share one sampler so they settle together
  localparam int RAW_W = SYNC_W;

  // Raw pins and their synchronised copies
  logic [RAW_W-1:0] raw_in;
  logic [RAW_W-1:0] synced;
  sel_status_t sel_s;
  grp_status_t grp_s;
  read_bus_t rb_s;

  assign raw_in = {sel_lines, grp_lines, read_bus_lines};

  level_sync #(
    .WIDTH(RAW_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .sync_out(synced)
  );

  assign sel_s = sel_status_t'(synced[RAW_W-1 -: SEL_W]);
  assign grp_s = grp_status_t'(synced[RAW_W-SEL_W-1 -: GRP_W]);
  assign rb_s = read_bus_t'(synced[BUS_W-1:0]);

  // Condition decode used by both output and event logic
  function automatic drive_cond_t cond_of(input sel_status_t s);
    cond_of = drive_cond_t'({s.backward_ready, s.forward_ready});
  endfunction : cond_of

  // Condition of the selected drive this cycle
  drive_cond_t cond_now;
  assign cond_now = cond_of(sel_s);

  // Data path state
  logic sprk_prev_r, sprk_prev_nxt;
  logic [CHAR_W-1:0] char_r, char_nxt;
  logic char_valid_r, char_valid_nxt;
  drive_cond_t cond_prev_r, cond_prev_nxt;
  logic first_r, first_nxt;
  logic unavail_r, unavail_nxt;
  logic oper_r, oper_nxt;
  logic [EV_W-1:0] ev_set;

  // APB and interrupt state
  logic [EV_W-1:0] ist_r, ist_nxt;
  logic [EV_W-1:0] imask_r, imask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic acc;
  logic rd_char;

  // Access phase not yet answered; a read of the slot empties it
  assign acc = psel && penable && !pready_r;
  assign rd_char = acc && !pwrite && (paddr == ADDR_READ_CHAR);

  // Character capture and condition tracking
  always_comb begin
    sprk_prev_nxt = rb_s.sprocket;
    char_nxt = char_r;
    char_valid_nxt = char_valid_r;
    ev_set = '0;
    if (rb_s.sprocket && !sprk_prev_r) begin
      char_nxt = rb_s.info;
      char_valid_nxt = 1'b1;
      ev_set[EV_CHAR] = 1'b1;
      // Unread character is overwritten; software learns of the loss
      ev_set[EV_OVERRUN] = char_valid_r;
    end
    // Reading the character slot empties it, unless a new one lands now
    if (rd_char && !ev_set[EV_CHAR]) begin
      char_valid_nxt = 1'b0;
    end
    cond_prev_nxt = cond_now;
    if (cond_now != cond_prev_r) begin
      ev_set[EV_COND_CHANGE] = 1'b1;
    end
    // Level events re-arm every cycle while the level stands
    // alerts raise one event
    ev_set[EV_BAD_TAPE] = grp_s.read_bad_tape_alert | grp_s.write_bad_tape_alert;
    first_nxt = (cond_now == COND_FIRST_BLOCK);
    unavail_nxt = (cond_now == COND_BUSY_OR_HELD);
    oper_nxt = !sel_s.main_unit_available;
    ev_set[EV_INTERVENE] = oper_nxt;
  end

  // One wait state: answer on the second access edge
  always_comb begin
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    imask_nxt = imask_r;
    // Set wins over a write-one clear in the same cycle
    ist_nxt = ist_r | ev_set;
    if (acc) begin
      case (paddr)
        ADDR_SEL_STATUS: prdata_nxt = {27'h0000000, sel_s};
        ADDR_GRP_STATUS: prdata_nxt = {24'h000000, grp_s};
        ADDR_CONDITION: prdata_nxt = {27'h0000000, oper_r, unavail_r, first_r, cond_prev_r};
        ADDR_READ_CHAR: prdata_nxt = {23'h000000, char_valid_r, rb_s.sprocket, char_r};
        ADDR_IRQ_STATUS: begin
          prdata_nxt = {27'h0000000, ist_r};
          if (pwrite) begin
            ist_nxt = (ist_r & ~pwdata[EV_W-1:0]) | ev_set;
          end
        end
        ADDR_IRQ_MASK: begin
          prdata_nxt = {27'h0000000, imask_r};
          if (pwrite) begin
            imask_nxt = pwdata[EV_W-1:0];
          end
        end
        // Unmapped offsets answer with an error and have no effect
        default: pslverr_nxt = 1'b1;
      endcase
      // Writes answer with zero data; read-only targets ignore them
      if (pwrite) begin
        prdata_nxt = 32'h0000_0000;
      end
    end
    // From next values, so irq follows its event by one edge only
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  // Data path registers; sprocket history resets to the idle low level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sprk_prev_r <= 1'b0;
      char_r <= '0;
      char_valid_r <= 1'b0;
      cond_prev_r <= COND_BUSY_OR_HELD;
      first_r <= 1'b0;
      unavail_r <= 1'b0;
      oper_r <= 1'b0;
    end else begin
      sprk_prev_r <= sprk_prev_nxt;
      char_r <= char_nxt;
      char_valid_r <= char_valid_nxt;
      cond_prev_r <= cond_prev_nxt;
      first_r <= first_nxt;
      unavail_r <= unavail_nxt;
      oper_r <= oper_nxt;
    end
  end

  // APB and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      imask_r <= IRQ_MASK_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Every output comes straight from a register
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign first_block = first_r;
  assign drive_unavailable = unavail_r;
  assign needs_operator = oper_r;

endmodule : tape_unit_status_decoder

// File: testbench/status_checker_asserts.sv
`timescale 1ns/1ps
// Watches the decoded condition flags against the raw selected-drive lines
module status_checker
  import tape_status_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire sel_status_t sel_lines, // Selected-drive lines
  input wire logic first_block, // First-block flag
  input wire logic drive_unavailable, // Busy or held flag
  input wire logic needs_operator // Intervention flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_first;
    (sel_lines.forward_ready && sel_lines.backward_ready) [*8] |-> first_block;
  endproperty
  a_first: assert property (p_first) else $error("first block flag missing");
  property p_busy;
    (!sel_lines.forward_ready && !sel_lines.backward_ready) [*8] |-> drive_unavailable;
  endproperty
  a_busy: assert property (p_busy) else $error("unavailable flag missing");
  property p_excl;
    first_block |-> !drive_unavailable && !needs_operator;
  endproperty
  a_excl: assert property (p_excl) else $error("condition flags conflict");
  property p_first_clr;
    !(sel_lines.forward_ready && sel_lines.backward_ready) [*8] |-> !first_block;
  endproperty
  a_first_clr: assert property (p_first_clr) else $error("first block flag stuck");
  property p_oper_clr;
    sel_lines.main_unit_available [*8] |-> !needs_operator;
  endproperty
  a_oper_clr: assert property (p_oper_clr) else $error("operator flag stuck");
  property p_oper;
    !sel_lines.main_unit_available [*8] |-> needs_operator;
  endproperty
  a_oper: assert property (p_oper) else $error("operator flag missing");
  property p_sync;
    $rose(first_block) |-> $past(sel_lines.forward_ready && sel_lines.backward_ready, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("flag rose before sync");
endmodule : status_checker

bind tape_unit_status_decoder status_checker chk_i (
  .pclk(pclk),
  .presetn(presetn),
  .sel_lines(sel_lines),
  .first_block(first_block),
  .drive_unavailable(drive_unavailable),
  .needs_operator(needs_operator)
);

// File: testbench/drive_model.sv
`timescale 1ns/1ps
// Drive group; thy bits: 0 main, 1 rewind lock, 2 rewind, 3 read, 4 write,
// 5 fwd, 6 bwd, 7 door, 8 no-erase, 9 plastic, 10 clutch, 11 bad tape
module drive_model
  import tape_status_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic [11:0] thy, // Thyratron and switch states
  output sel_status_t sel_lines, // Selected-drive lines
  output grp_status_t grp_lines, // Active-drive lines
  output read_bus_t read_bus_lines // Read bus
);
  logic ok;
  initial read_bus_lines = 8'h00;
  // Main fired and door closed
  assign ok = thy[0] & thy[7];
  assign sel_lines = {thy[8], ok & thy[1], ok & ~|thy[5:1], ok & ~|{thy[6], thy[4:1]},
    ok & ~thy[1]};
  assign grp_lines = {thy[3] & thy[9], thy[4] & thy[11], thy[3] & thy[11], thy[4] & thy[5],
    thy[3] & thy[6], thy[3] & thy[5], thy[4] & thy[10], ~thy[4]};
  // one char per sprocket pulse, 62.5 ns high after 62.5 ns of data setup, idle low
  task automatic send(input logic [6:0] c);
    @(posedge pclk);
    read_bus_lines.info <= c;
    #62.5;
    read_bus_lines.sprocket <= 1'b1;
    #62.5;
    read_bus_lines.sprocket <= 1'b0;
    read_bus_lines.info <= ~c; // Stale data is not held
    // Let the low sprocket settle through the sampler
    repeat (8) @(posedge pclk);
  endtask : send
endmodule : drive_model

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tape_status_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, first_block, drive_unavailable, needs_operator, err;
  logic [11:0] thy = 12'h000;
  logic [2:0] pins;
  sel_status_t sel_lines;
  grp_status_t grp_lines;
  read_bus_t read_bus_lines;
  int miscompares = 0;
  int comparisons = 0;
  // Drive states and the expected selected, group and condition words
  logic [11:0] tv [8] = '{12'h081, 12'hAA9, 12'h083, 12'hDB1, 12'h0C1, 12'h0C9, 12'h080, 12'h0A1};
  logic [7:0] es [8] = '{8'h07, 8'h01, 8'h08, 8'h11, 8'h05, 8'h01, 8'h00, 8'h03};
  logic [7:0] eg [8] = '{8'h01, 8'hA5, 8'h01, 8'h52, 8'h01, 8'h09, 8'h01, 8'h01};
  logic [7:0] ec [8] = '{8'h07, 8'h08, 8'h18, 8'h08, 8'h02, 8'h08, 8'h18, 8'h01};

  always #5 pclk = ~pclk;

  // Condition flag pins in the layout of the condition word
  assign pins = {needs_operator, drive_unavailable, first_block};

  tape_unit_status_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sel_lines(sel_lines), .grp_lines(grp_lines),
    .read_bus_lines(read_bus_lines), .irq(irq), .first_block(first_block),
    .drive_unavailable(drive_unavailable), .needs_operator(needs_operator));
  drive_model dm (.pclk(pclk), .thy(thy), .sel_lines(sel_lines), .grp_lines(grp_lines),
    .read_bus_lines(read_bus_lines));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // One APB transfer; idle edge first so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end else begin
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 50) begin
      @(posedge pclk);
      n++;
    end
    chk("irq", {31'h0, irq}, {31'h0, v});
    if (irq !== v) begin
      final_report();
    end
  endtask : wait_irq

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_IRQ_MASK, 32'h0, q);
    chk("mask reset", q, {27'h0, IRQ_MASK_RST});
    apb(1'b0, 12'h018, 32'h0, q);
    chk("unmapped data", q, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      thy <= tv[i];
      repeat (8) @(posedge pclk);
      apb(1'b0, ADDR_SEL_STATUS, 32'h0, q);
      chk("sel status", q, {24'h0, es[i]});
      apb(1'b0, ADDR_GRP_STATUS, 32'h0, q);
      chk("grp status", q, {24'h0, eg[i]});
      apb(1'b0, ADDR_CONDITION, 32'h0, q);
      chk("condition", q, {24'h0, ec[i]});
      chk("flag pins", {29'h0, pins}, {29'h0, ec[i][4:2]});
    end
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, q);
    chk("level events", q, 32'h1C);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1, q);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1F, q);
    dm.send(7'h5A);
    wait_irq(1'b1);
    apb(1'b0, ADDR_READ_CHAR, 32'h0, q);
    chk("read char", q, 32'h15A);
    dm.send(7'h33);
    dm.send(7'h44);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, q);
    chk("overrun", q & 32'h3, 32'h3);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h3, q);
    wait_irq(1'b0);
    final_report();
  end
endmodule : tb_top
